//--- design/reset_warmup_sequencer.sv
// reset and warm-up sequencer top with apb register slave
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module reset_warmup_sequencer #(
  parameter int WARMUP_COUNT = rst_seq_pkg::WARMUP_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // reset sources and the mode strap
  input  wire logic        por_reset,
  input  wire logic        ext_reset_n,
  input  wire logic [5:0]  internal_reset_req,
  input  wire logic        serial_prom_mode,
  // nvm for trimming data
  output logic             nvm_rd_en,
  output logic [3:0]       nvm_addr,
  input  wire logic [7:0]  nvm_rdata,
  // controls towards cpu and peripherals
  output logic             cpu_reset_n,
  output logic             periph_reset_n,
  output logic             io_hiz,
  output logic             warmup_done,
  output logic [15:0]      pc_reset_value,
  output logic [7:0]       stack_pointer_init,
  output logic             register_bank_select,
  output logic             interrupt_master_enable,
  output logic             interrupt_clear,
  output logic             hf_osc_en,
  output logic             lf_osc_en,
  output logic             prescaler_clear,
  output logic             wdt_enable,
  output logic             vdet_enable,
  output logic [7:0]       trim_data,
  output logic             trim_abnormal
);
  import rst_seq_pkg::*;

  // ******************************************************************
  // reset collection
  // ******************************************************************
  seq_state_t  state_reg;
  seq_state_t  state_next;
  logic        soft_reset_reg;
  logic        lf_osc_reg;
  logic        vdet_reg;
  logic        prom_mode_reg;
  logic        hard_reset;
  logic        any_reset;
  logic        release_now;

  seq_if sif ();

  assign hard_reset  = por_reset | ~ext_reset_n;
  // every source lands on the same controller and the same sequence
  assign any_reset   = hard_reset | (|internal_reset_req)
                     | soft_reset_reg;
  assign release_now = (state_reg == ST_WARMUP) && !any_reset
                     && sif.expired && sif.load_done;

  // ******************************************************************
  // sub-blocks
  // ******************************************************************
  warmup_counter #(
    .WARMUP_COUNT (WARMUP_COUNT)
  ) u_counter (
    .pclk    (pclk),
    .presetn (presetn),
    .sif     (sif.ctr_mp)
  );

  trim_loader u_loader (
    .pclk    (pclk),
    .presetn (presetn),
    .sif     (sif.ldr_mp)
  );

  assign sif.run       = (state_reg == ST_WARMUP) && !any_reset;
  assign sif.nvm_rdata = nvm_rdata;
  assign nvm_rd_en     = sif.nvm_rd_en;
  assign nvm_addr      = sif.nvm_addr;
  assign trim_data     = sif.trim_word;
  assign trim_abnormal = sif.trim_bad;

  // ******************************************************************
  // sequencer state
  // ******************************************************************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RESET: begin
        if (!any_reset) begin
          state_next = ST_WARMUP;
        end
      end
      ST_WARMUP: begin
        if (any_reset) begin
          state_next = ST_RESET;
        end else if (release_now) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (any_reset) begin
          state_next = ST_RESET;
        end
      end
      default: begin
        state_next = ST_RESET;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // the mode strap is only taken while the cpu is held
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prom_mode_reg <= 1'b0;
    end else if (state_reg == ST_RESET) begin
      prom_mode_reg <= serial_prom_mode;
    end
  end

  // ******************************************************************
  // cpu and peripheral controls
  // ******************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_reset_n    <= 1'b0;
      periph_reset_n <= 1'b0;
      io_hiz         <= 1'b1;
      warmup_done    <= 1'b0;
      wdt_enable     <= 1'b0;
    end else begin
      cpu_reset_n    <= (state_next == ST_RUN);
      periph_reset_n <= (state_next == ST_RUN);
      io_hiz         <= (state_next != ST_RUN);
      warmup_done    <= release_now;
      wdt_enable     <= (state_next == ST_RUN);
    end
  end

  // cpu-side forced values; ram, general registers and flags get none
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_reset_value          <= PC_MCU_MODE;
      stack_pointer_init      <= SP_RESET;
      register_bank_select    <= 1'b0;
      interrupt_master_enable <= 1'b0;
      interrupt_clear         <= 1'b1;
    end else begin
      pc_reset_value          <= prom_mode_reg ? PC_PROM_MODE
                                               : PC_MCU_MODE;
      stack_pointer_init      <= SP_RESET;
      register_bank_select    <= 1'b0;
      interrupt_master_enable <= 1'b0;
      // high on the release edge too, so no latch survives into run
      interrupt_clear         <= (state_next != ST_RUN)
                                 || (state_reg != ST_RUN);
    end
  end

  // ******************************************************************
  // clock and detector controls
  // ******************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hf_osc_en       <= 1'b1;
      lf_osc_en       <= 1'b0;
      prescaler_clear <= 1'b1;
      vdet_enable     <= 1'b0;
    end else begin
      hf_osc_en       <= 1'b1;
      // on a cycle after release, off on the same edge as the cpu hold
      lf_osc_en       <= lf_osc_reg && (state_reg == ST_RUN)
                         && (state_next == ST_RUN);
      prescaler_clear <= (state_next != ST_RUN);
      vdet_enable     <= vdet_reg;
    end
  end

  // ******************************************************************
  // apb slave
  // ******************************************************************
  logic        acc_phase;
  logic        wr_take;
  logic        addr_ok;
  logic [31:0] rd_mux;

  assign acc_phase = psel && penable && !pready;
  assign wr_take   = psel && penable && pready && pwrite;
  assign addr_ok   = (paddr == STATUS_OFFSET) || (paddr == CTRL_OFFSET)
                   || (paddr == TRIM_OFFSET) || (paddr == PCVAL_OFFSET);

  always_comb begin
    case (paddr)
      STATUS_OFFSET: rd_mux = {26'h0, prom_mode_reg, sif.trim_bad,
                               sif.load_done, state_reg == ST_RUN,
                               state_reg == ST_WARMUP,
                               state_reg == ST_RESET};
      CTRL_OFFSET:   rd_mux = {29'h0, vdet_reg, lf_osc_reg,
                               soft_reset_reg};
      TRIM_OFFSET:   rd_mux = {24'h0, sif.trim_word};
      PCVAL_OFFSET:  rd_mux = {16'h0, pc_reset_value};
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  // one wait state: pready rises in the cycle after penable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= acc_phase;
      pslverr <= acc_phase && !addr_ok;
      prdata  <= (acc_phase && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // control bits: a sequencer reset beats a software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_reset_reg <= CTRL_RESET[CTRL_SOFT_BIT];
      lf_osc_reg     <= CTRL_RESET[CTRL_LFOSC_BIT];
    end else if (state_reg == ST_RESET) begin
      soft_reset_reg <= 1'b0;
      lf_osc_reg     <= 1'b0;
    end else if (wr_take && paddr == CTRL_OFFSET) begin
      soft_reset_reg <= pwdata[CTRL_SOFT_BIT];
      lf_osc_reg     <= pwdata[CTRL_LFOSC_BIT];
    end
  end

  // internal resets leave the detector setting as it was
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vdet_reg <= CTRL_RESET[CTRL_VDET_BIT];
    end else if (hard_reset) begin
      vdet_reg <= 1'b0;
    end else if (wr_take && paddr == CTRL_OFFSET) begin
      vdet_reg <= pwdata[CTRL_VDET_BIT];
    end
  end

endmodule : reset_warmup_sequencer
`default_nettype wire

//--- design/rst_seq_pkg.sv
// constants and types shared by the reset and warm-up sequencer
// ********************************************************************
// ********************************************************************
package rst_seq_pkg;

  // ******************************************************************
  // register map
  // ******************************************************************
  localparam logic [7:0]  STATUS_OFFSET   = 8'h00;
  localparam logic [7:0]  CTRL_OFFSET     = 8'h04;
  localparam logic [7:0]  TRIM_OFFSET     = 8'h08;
  localparam logic [7:0]  PCVAL_OFFSET    = 8'h0C;
  localparam int          CTRL_SOFT_BIT   = 0;
  localparam int          CTRL_LFOSC_BIT  = 1;
  localparam int          CTRL_VDET_BIT   = 2;
  localparam logic [2:0]  CTRL_RESET      = 3'h0;

  // ******************************************************************
  // cpu reset values
  // ******************************************************************
  localparam logic [15:0] PC_MCU_MODE     = 16'hFFFE;
  localparam logic [15:0] PC_PROM_MODE    = 16'h1FFE;
  localparam logic [7:0]  SP_RESET        = 8'hFF;

  // ******************************************************************
  // warm-up and trimming
  // ******************************************************************
  localparam int          WARMUP_CYCLES   = 1024;
  localparam int          WARMUP_W        = 16;
  localparam logic [3:0]  TRIM_ADDR_DATA  = 4'h0;
  localparam logic [3:0]  TRIM_ADDR_CHECK = 4'h1;
  localparam logic [7:0]  TRIM_RESET      = 8'h00;

  typedef enum logic [1:0] {
    ST_RESET,
    ST_WARMUP,
    ST_RUN
  } seq_state_t;

endpackage : rst_seq_pkg

//--- design/seq_if.sv
// carrier between the sequencer and its counter and trimming loader
`timescale 1ns/1ps
`default_nettype none
interface seq_if;
  logic                           run;
  logic                           expired;
  logic                           load_done;
  logic                           trim_bad;
  logic [7:0]                     trim_word;
  logic                           nvm_rd_en;
  logic [3:0]                     nvm_addr;
  logic [7:0]                     nvm_rdata;

  modport main_mp (output run, output nvm_rdata, input expired,
                   input load_done, input trim_bad, input trim_word,
                   input nvm_rd_en, input nvm_addr);
  modport ctr_mp  (input run, output expired);
  modport ldr_mp  (input run, input nvm_rdata, output load_done,
                   output trim_bad, output trim_word, output nvm_rd_en,
                   output nvm_addr);
endinterface : seq_if
`default_nettype wire

//--- design/warmup_counter.sv
// warm-up counter: counts clock cycles while run is high, then holds
`timescale 1ns/1ps
`default_nettype none
module warmup_counter #(
  parameter int WARMUP_COUNT = rst_seq_pkg::WARMUP_CYCLES
) (
  input  wire logic pclk,
  input  wire logic presetn,
  seq_if.ctr_mp     sif
);
  import rst_seq_pkg::*;

  localparam logic [WARMUP_W-1:0] LAST = WARMUP_W'(WARMUP_COUNT - 1);

  logic [WARMUP_W-1:0] count_reg;

  // cleared whenever run drops, so a new reset restarts from zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= '0;
    end else if (!sif.run) begin
      count_reg <= '0;
    end else if (count_reg != LAST) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sif.expired <= 1'b0;
    end else begin
      sif.expired <= sif.run && (count_reg == LAST);
    end
  end

endmodule : warmup_counter
`default_nettype wire

//--- design/trim_loader.sv
// trimming loader: reads a data byte and its complement from nvm
`timescale 1ns/1ps
`default_nettype none
module trim_loader (
  input  wire logic pclk,
  input  wire logic presetn,
  seq_if.ldr_mp     sif
);
  import rst_seq_pkg::*;

  logic [1:0] step_reg;

  // nvm answers in the cycle the read strobe stands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_reg      <= 2'h0;
      sif.nvm_rd_en <= 1'b0;
      sif.nvm_addr  <= TRIM_ADDR_DATA;
      sif.load_done <= 1'b0;
      sif.trim_bad  <= 1'b0;
      sif.trim_word <= TRIM_RESET;
    end else if (!sif.run) begin
      step_reg      <= 2'h0;
      sif.nvm_rd_en <= 1'b0;
      sif.load_done <= 1'b0;
    end else begin
      case (step_reg)
        2'h0: begin
          sif.nvm_rd_en <= 1'b1;
          sif.nvm_addr  <= TRIM_ADDR_DATA;
          step_reg      <= 2'h1;
        end
        2'h1: begin
          sif.trim_word <= sif.nvm_rdata;
          sif.nvm_addr  <= TRIM_ADDR_CHECK;
          step_reg      <= 2'h2;
        end
        2'h2: begin
          sif.nvm_rd_en <= 1'b0;
          // the check byte must be the complement of the data byte
          sif.trim_bad  <= (sif.nvm_rdata != ~sif.trim_word);
          sif.load_done <= 1'b1;
          step_reg      <= 2'h3;
        end
        default: begin
          step_reg <= 2'h3;
        end
      endcase
    end
  end

endmodule : trim_loader
`default_nettype wire

//--- tb/rst_seq_monitor.sv
// port checker for the reset and warm-up sequencer
`timescale 1ns/1ps
`default_nettype none
module rst_seq_monitor #(
  parameter int WARMUP_COUNT = 8
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        por_reset,
  input wire logic        ext_reset_n,
  input wire logic [5:0]  internal_reset_req,
  input wire logic        serial_prom_mode,
  input wire logic        nvm_rd_en,
  input wire logic [3:0]  nvm_addr,
  input wire logic        cpu_reset_n,
  input wire logic        periph_reset_n,
  input wire logic        io_hiz,
  input wire logic        warmup_done,
  input wire logic [15:0] pc_reset_value,
  input wire logic [7:0]  stack_pointer_init,
  input wire logic        register_bank_select,
  input wire logic        interrupt_master_enable,
  input wire logic        interrupt_clear,
  input wire logic        hf_osc_en,
  input wire logic        lf_osc_en,
  input wire logic        prescaler_clear,
  input wire logic        wdt_enable,
  input wire logic        vdet_enable
);
  import rst_seq_pkg::*;
  // slack for the two-cycle hand-off and the trim load
  localparam int WARMUP_MAX = WARMUP_COUNT + 10;
  logic        src;
  logic [15:0] quiet_reg;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  assign src = por_reset | ~ext_reset_n | (|internal_reset_req);
  // cycles held with no source active; any source restarts it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) quiet_reg <= 16'h0000;
    else if (src || cpu_reset_n) quiet_reg <= 16'h0000;
    else if (quiet_reg != 16'hFFFF) quiet_reg <= quiet_reg + 16'h0001;
  end
  sequence trim_reads;
    nvm_addr == TRIM_ADDR_DATA ##1 nvm_rd_en && nvm_addr == TRIM_ADDR_CHECK
      ##1 !nvm_rd_en;
  endsequence
  sequence held_src;
    src [*2];
  endsequence
  sequence let_go;
    cpu_reset_n && periph_reset_n && wdt_enable && !io_hiz && !prescaler_clear;
  endsequence
  chk_src_holds: assert property (held_src |-> !cpu_reset_n && io_hiz)
    else $error("source active but cpu free");
  chk_release_set: assert property (warmup_done |-> let_go)
    else $error("release outputs not together");
  chk_rise_cause: assert property ($rose(cpu_reset_n) |-> warmup_done)
    else $error("cpu freed without pulse");
  chk_wdt_with_cpu: assert property ($rose(wdt_enable) |-> $rose(cpu_reset_n))
    else $error("watchdog enabled alone");
  chk_warmup_min: assert property (warmup_done |-> quiet_reg >= WARMUP_COUNT)
    else $error("warm-up too short");
  chk_warmup_max: assert property (!cpu_reset_n |-> quiet_reg <= WARMUP_MAX)
    else $error("warm-up too long");
  chk_trim_order: assert property ($rose(nvm_rd_en) |-> trim_reads)
    else $error("trim read order");
  chk_trim_warm: assert property (nvm_rd_en |-> !cpu_reset_n)
    else $error("trim read while running");
  chk_pc_mode: assert property ((!cpu_reset_n && $stable(serial_prom_mode))[*3]
    |-> pc_reset_value == (serial_prom_mode ? PC_PROM_MODE : PC_MCU_MODE))
    else $error("pc reset value");
  chk_sp_bank: assert property (stack_pointer_init == SP_RESET
    && !register_bank_select) else $error("sp or bank value");
  chk_irq_clear: assert property (!cpu_reset_n |-> interrupt_clear
    && !interrupt_master_enable) else $error("interrupts not cleared");
  chk_hf_osc_on: assert property (hf_osc_en)
    else $error("hf oscillator off");
  chk_lf_osc_off: assert property (!cpu_reset_n |-> !lf_osc_en ##1 !lf_osc_en)
    else $error("lf oscillator on early");
  chk_prescale_held: assert property (!cpu_reset_n |-> prescaler_clear)
    else $error("prescaler not cleared");
  chk_vdet_cleared: assert property ((por_reset || !ext_reset_n)[*3]
    |-> !vdet_enable) else $error("detector kept on hard reset");
endmodule : rst_seq_monitor
bind reset_warmup_sequencer rst_seq_monitor #(.WARMUP_COUNT(WARMUP_COUNT))
  u_mon (.pclk, .presetn, .por_reset, .ext_reset_n, .internal_reset_req,
  .serial_prom_mode, .nvm_rd_en, .nvm_addr, .cpu_reset_n, .periph_reset_n,
  .io_hiz, .warmup_done, .pc_reset_value, .stack_pointer_init,
  .register_bank_select, .interrupt_master_enable, .interrupt_clear,
  .hf_osc_en, .lf_osc_en, .prescaler_clear, .wdt_enable, .vdet_enable);
`default_nettype wire

//--- tb/nvm_trim_model.sv
// model of the non-volatile trimming memory
`timescale 1ns/1ps
`default_nettype none
module nvm_trim_model #(
  parameter logic [7:0] TRIM_BYTE = 8'h5A
) (
  input  wire logic       pclk,
  input  wire logic       corrupt,
  input  wire logic       nvm_rd_en,
  input  wire logic [3:0] nvm_addr,
  output var  logic [7:0] nvm_rdata
);
  import rst_seq_pkg::*;
  logic [7:0] idle_reg = 8'hC3;
  // idle data churns so a read taken off the strobe shows up as wrong
  always @(posedge pclk) begin
    if (!nvm_rd_en) idle_reg <= ~idle_reg ^ 8'h3C;
  end
  // answers within the cycle the address stands; the loader takes it
  // at the edge that ends that cycle
  always_comb begin
    if (!nvm_rd_en) nvm_rdata = idle_reg;
    else if (nvm_addr == TRIM_ADDR_DATA) nvm_rdata = TRIM_BYTE;
    else nvm_rdata = corrupt ? TRIM_BYTE : ~TRIM_BYTE;
  end
endmodule : nvm_trim_model
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the reset and warm-up sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rst_seq_pkg::*;
  localparam int         WU = 8;
  localparam logic [7:0] TB = 8'h5A;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, por_reset = 1'b0, ext_reset_n = 1'b1;
  logic serial_prom_mode = 1'b0, corrupt = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [5:0]  internal_reset_req = 6'h00;
  logic [3:0]  nvm_addr;
  logic [7:0]  nvm_rdata, stack_pointer_init, trim_data;
  logic [15:0] pc_reset_value;
  logic pready, pslverr, nvm_rd_en, cpu_reset_n, periph_reset_n, io_hiz, e;
  logic warmup_done, register_bank_select, interrupt_master_enable;
  logic interrupt_clear, hf_osc_en, lf_osc_en, prescaler_clear, wdt_enable;
  logic vdet_enable, trim_abnormal;
  int   num_errors = 0, samples_checked = 0;
  always #5 pclk = ~pclk;
  reset_warmup_sequencer #(.WARMUP_COUNT(WU)) DUT (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .por_reset, .ext_reset_n, .internal_reset_req, .serial_prom_mode,
    .nvm_rd_en, .nvm_addr, .nvm_rdata, .cpu_reset_n, .periph_reset_n,
    .io_hiz, .warmup_done, .pc_reset_value, .stack_pointer_init,
    .register_bank_select, .interrupt_master_enable, .interrupt_clear,
    .hf_osc_en, .lf_osc_en, .prescaler_clear, .wdt_enable, .vdet_enable,
    .trim_data, .trim_abnormal);
  nvm_trim_model #(.TRIM_BYTE(TB)) u_nvm (.pclk, .corrupt, .nvm_rd_en,
    .nvm_addr, .nvm_rdata);
  // ****************************************************************
  // compare, report and bus tasks
  // ****************************************************************
  task automatic tally_and_finish;
    if (num_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic fail(input string m);
    num_errors++;
    $display("CHECK FAILED %0t %s", $time, m);
  endtask : fail
  task automatic chk_bit(input logic g, input logic x, input string m);
    samples_checked++;
    if (g !== x) fail(m);
  endtask : chk_bit
  task automatic chk_val(input logic [31:0] g, input logic [31:0] x,
                         input string m);
    samples_checked++;
    if (g !== x) fail(m);
  endtask : chk_val
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick
  // starts one edge late so a release never shares a step with a request
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      fail("apb stall");
      tally_and_finish;
    end
  endtask : apb
  task automatic drive_src(input int w, input logic on);
    if (w == 0) por_reset <= on;
    else if (w == 1) ext_reset_n <= ~on;
    else internal_reset_req[w-2] <= on;
  endtask : drive_src
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic pulse(input int w);
    drive_src(w, 1'b1);
    tick(4);
    chk_bit(cpu_reset_n | periph_reset_n | wdt_enable, 1'b0, "not held");
    chk_bit(io_hiz & prescaler_clear & interrupt_clear, 1'b1, "pins");
    drive_src(w, 1'b0);
  endtask : pulse
  task automatic boot(input logic [15:0] pc, input logic bad);
    int c;
    c = 0;
    do begin
      @(posedge pclk);
      c++;
    end while (warmup_done !== 1'b1 && c < 60);
    if (c >= 60) begin
      fail("no warm-up end");
      tally_and_finish;
    end
    chk_bit(c >= WU, 1'b1, "warm-up short");
    chk_bit(cpu_reset_n & periph_reset_n & wdt_enable, 1'b1, "held");
    chk_bit(io_hiz | prescaler_clear | lf_osc_en, 1'b0, "state");
    chk_val(pc_reset_value, pc, "pc value");
    chk_val(trim_data, TB, "trim byte");
    chk_bit(trim_abnormal, bad, "trim check");
    tick(2);
    chk_bit(interrupt_clear | interrupt_master_enable, 1'b0, "irq");
  endtask : boot
  task automatic t_restart;
    pulse(0);
    tick(5);
    chk_bit(cpu_reset_n, 1'b0, "released early");
    drive_src(2, 1'b1);
    tick(2);
    drive_src(2, 1'b0);
    boot(PC_MCU_MODE, 1'b0);
  endtask : t_restart
  task automatic t_or_release;
    por_reset <= 1'b1;
    ext_reset_n <= 1'b0;
    tick(3);
    por_reset <= 1'b0;
    tick(15);
    chk_bit(cpu_reset_n, 1'b0, "pin reset ignored");
    ext_reset_n <= 1'b1;
    boot(PC_MCU_MODE, 1'b0);
  endtask : t_or_release
  task automatic t_modes;
    serial_prom_mode <= 1'b1;
    pulse(0);
    boot(PC_PROM_MODE, 1'b0);
    apb(1'b0, PCVAL_OFFSET, 32'h0);
    chk_val(r, {16'h0000, PC_PROM_MODE}, "pc register");
    serial_prom_mode <= 1'b0;
    pulse(1);
    boot(PC_MCU_MODE, 1'b0);
  endtask : t_modes
  task automatic t_detector;
    for (int w = 0; w < 2; w++) begin
      apb(1'b1, CTRL_OFFSET, 32'h6);
      tick(2);
      chk_bit(lf_osc_en, 1'b1, "lf osc not enabled");
      pulse(2 + w);
      boot(PC_MCU_MODE, 1'b0);
      chk_bit(vdet_enable, 1'b1, "detector lost");
      pulse(w);
      boot(PC_MCU_MODE, 1'b0);
      chk_bit(vdet_enable, 1'b0, "detector kept");
    end
  endtask : t_detector
  task automatic t_bad_trim;
    corrupt <= 1'b1;
    pulse(4);
    boot(PC_MCU_MODE, 1'b1);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    chk_bit(r[4], 1'b1, "status trim flag");
    corrupt <= 1'b0;
    pulse(5);
    boot(PC_MCU_MODE, 1'b0);
    apb(1'b1, 8'h40, 32'hFFFF_FFFF);
    chk_bit(e, 1'b1, "unmapped write");
    apb(1'b0, 8'h40, 32'h0);
    chk_val({r[31:1], e}, 32'h1, "unmapped read");
    apb(1'b1, CTRL_OFFSET, 32'h1);
    tick(2);
    chk_bit(cpu_reset_n, 1'b0, "soft reset ignored");
    boot(PC_MCU_MODE, 1'b0);
    apb(1'b0, CTRL_OFFSET, 32'h0);
    chk_val(r, 32'h0, "soft bit kept");
  endtask : t_bad_trim
  initial begin
    tick(4);
    pulse(1);
    presetn <= 1'b1;
    boot(PC_MCU_MODE, 1'b0);
    for (int w = 0; w < 8; w++) begin
      pulse(w);
      boot(PC_MCU_MODE, 1'b0);
    end
    t_restart;
    t_or_release;
    t_modes;
    t_detector;
    t_bad_trim;
    tally_and_finish;
  end
endmodule : tb_top
`default_nettype wire
